// file: common/tpmi_pkg.sv
// shared constants for the test port message interpreter, simulator side
package tpmi_pkg;
    // message identifiers sent by the simulator
    localparam logic [7:0] ID_VOLUME_UP = 8'h33;
    localparam logic [7:0] ID_VOLUME_DOWN = 8'h34;
    localparam logic [7:0] ID_STATUS_REQ = 8'h35;
    localparam logic [7:0] ID_INDICATION_REQ = 8'h36;
    localparam logic [7:0] ID_POWER_REQ = 8'h37;
    localparam logic [7:0] ID_ALERT_REQ = 8'h38;
    localparam logic [7:0] ID_SHORT_MSG_REQ = 8'h39;
    localparam logic [7:0] ID_KEYSTROKE = 8'h3a;
    localparam logic [7:0] ID_HANDSET_DOWN = 8'h40;
    localparam logic [7:0] ID_HANDSET_UP = 8'h41;
    localparam logic [7:0] ID_BEARER_SELECT = 8'h46;
    localparam logic [7:0] ID_TX_POWER_SET = 8'h50;
    localparam logic [7:0] ID_FULL_RESET = 8'hff;
    // message identifiers sent by the handset
    localparam logic [7:0] ID_ALERT_ON = 8'h3c;
    localparam logic [7:0] ID_ALERT_OFF = 8'h3d;
    localparam logic [7:0] ID_STATUS_RESP = 8'h5b;
    localparam logic [7:0] ID_INDICATION_RESP = 8'h5c;
    localparam logic [7:0] ID_POWER_RESP = 8'h5d;
    localparam logic [7:0] ID_SHORT_MSG = 8'h65;
    localparam logic [7:0] ID_NO_SHORT_MSG = 8'h66;
    localparam logic [7:0] ID_INTERNAL_FAULT = 8'hf0;
    localparam logic [7:0] ID_UNRECOGNISED = 8'hf1;
    localparam logic [7:0] ID_UNPERFORMABLE = 8'hf2;
    // identifier ranges
    localparam logic [7:0] GENERAL_LO = 8'h32;
    localparam logic [7:0] GENERAL_HI = 8'hb3;
    localparam logic [7:0] MAKER_LO = 8'hb4;
    localparam logic [7:0] MAKER_HI = 8'hd1;
    localparam logic [7:0] MAKER_PRIV_LO = 8'hd2;
    localparam logic [7:0] MAKER_PRIV_HI = 8'hef;
    localparam logic [7:0] ERROR_LO = 8'hf0;
    // layer 2 flow-control codes, never usable as identifiers
    localparam logic [7:0] FLOW_ACK = 8'h06;
    localparam logic [7:0] FLOW_NAK = 8'h15;
    localparam logic [7:0] FLOW_RESUME = 8'h11;
    localparam logic [7:0] FLOW_STOP = 8'h13;
    // key codes
    localparam logic [7:0] KEY_HASH = 8'h23;
    localparam logic [7:0] KEY_STAR = 8'h2a;
    localparam logic [7:0] KEY_PLUS = 8'h2b;
    localparam logic [7:0] KEY_DIGIT0 = 8'h30;
    localparam logic [7:0] KEY_DIGIT9 = 8'h39;
    localparam logic [7:0] KEY_END = 8'h12;
    localparam logic [7:0] KEY_SEND = 8'h14;
    // sizes: identifier plus payload fits 255 data octets of a frame
    localparam logic [7:0] MAX_PAYLOAD = 8'hfe;
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 8;
    // reset values
    localparam logic [7:0] BYTE_RST = 8'h00;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_ID = 2'b01,
        TX_PAYLOAD = 2'b10,
        TX_ERROR = 2'b11
    } tpmi_tx_state_t;
endpackage : tpmi_pkg

// file: design/tpmi_fifo.sv
// small synchronous valid/ready fifo for the outgoing payload bytes
`timescale 1ns/1ps
module tpmi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // filling side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // draining side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    // honest flags straight from the occupancy count
    assign in_ready_out = (count_ff != DEPTH[AW:0]);
    assign out_valid_out = (count_ff != '0);
    assign out_data_out = mem_ff[rd_ptr_ff];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // storage has no reset, contents are qualified by the count
    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_in;
        end
    end

    // pointers and occupancy; depth is a power of two so pointers wrap
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

    fifo_bound_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
        count_ff <= DEPTH[AW:0]) else $error("fifo count over depth");
endmodule : tpmi_fifo

// file: design/tpmi_host.sv
// simulator-side message interpreter: sends commands, decodes handset answers
`timescale 1ns/1ps
module tpmi_host
    import tpmi_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    // configuration
    input wire logic maker_ids_en_in,
    // command request
    input wire logic cmd_valid_in,
    output logic cmd_ready_out,
    input wire logic [7:0] cmd_id_in,
    input wire logic [7:0] cmd_len_in,
    output logic cmd_reject_out,
    // command payload bytes
    input wire logic pay_valid_in,
    output logic pay_ready_out,
    input wire logic [7:0] pay_data_in,
    // message bytes to the framer
    output logic tx_valid_out,
    input wire logic tx_ready_in,
    output logic [7:0] tx_data_out,
    output logic tx_last_out,
    output logic key_bad_out,
    // message bytes from the framer
    input wire logic rx_valid_in,
    input wire logic [7:0] rx_data_in,
    input wire logic rx_last_in,
    input wire logic rx_frame_ok_in,
    // decoded answers
    output logic resp_valid_out,
    output logic [7:0] resp_id_out,
    output logic [7:0] resp_data_out,
    output logic alert_on_out,
    output logic short_msg_out,
    output logic [7:0] dev_error_out
);
    ////////////////////////////////////////////////////////////////////////
    // decoding functions

    // identifiers the simulator may send
    function automatic logic id_sendable(input logic [7:0] id, input logic ext_en);
        logic ok;
        ok = 1'b0;
        // assigned general and error ids only
        unique case (id)
            ID_VOLUME_UP, ID_VOLUME_DOWN, ID_STATUS_REQ, ID_INDICATION_REQ,
            ID_POWER_REQ, ID_ALERT_REQ, ID_SHORT_MSG_REQ, ID_KEYSTROKE,
            ID_HANDSET_DOWN, ID_HANDSET_UP, ID_BEARER_SELECT, ID_TX_POWER_SET,
            ID_UNRECOGNISED, ID_FULL_RESET: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        if (ext_en && id >= MAKER_LO && id <= MAKER_HI) begin
            ok = 1'b1;
        end
        // flow codes never pass, even if a table entry were to clash
        if (id == FLOW_ACK || id == FLOW_NAK || id == FLOW_RESUME || id == FLOW_STOP) begin
            ok = 1'b0;
        end
        return ok;
    endfunction : id_sendable

    // identifiers the simulator understands from the handset
    function automatic logic id_known(input logic [7:0] id, input logic ext_en);
        logic ok;
        ok = 1'b0;
        unique case (id)
            ID_ALERT_ON, ID_ALERT_OFF, ID_STATUS_RESP, ID_INDICATION_RESP,
            ID_POWER_RESP, ID_SHORT_MSG, ID_NO_SHORT_MSG, ID_INTERNAL_FAULT,
            ID_UNRECOGNISED, ID_UNPERFORMABLE: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        if (ext_en && id >= MAKER_LO && id <= MAKER_PRIV_HI) begin
            ok = 1'b1;
        end
        return ok;
    endfunction : id_known

    // legal key codes of a keystroke payload
    function automatic logic key_legal(input logic [7:0] k);
        return (k >= KEY_DIGIT0 && k <= KEY_DIGIT9) || k == KEY_END || k == KEY_SEND
            || k == KEY_HASH || k == KEY_STAR || k == KEY_PLUS;
    endfunction : key_legal

    ////////////////////////////////////////////////////////////////////////
    // reset release

    logic [1:0] rst_sync_ff;
    logic rst_n;

    // two flops so release never lands near a clock edge
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    ////////////////////////////////////////////////////////////////////////
    // payload buffer

    logic fifo_valid;
    logic fifo_ready;
    logic [7:0] fifo_data;

    tpmi_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_pay_fifo (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n),
        .in_valid_in(pay_valid_in),
        .in_ready_out(pay_ready_out),
        .in_data_in(pay_data_in),
        .out_valid_out(fifo_valid),
        .out_ready_in(fifo_ready),
        .out_data_out(fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // transmit sequencer

    tpmi_tx_state_t state_ff;
    logic [7:0] id_ff;
    logic [7:0] rem_ff;
    logic err_pend_ff;
    logic cmd_take;
    logic cmd_ok;
    logic tx_fire;
    logic err_set;

    assign cmd_ready_out = (state_ff == TX_IDLE) && !err_pend_ff;
    assign cmd_take = cmd_valid_in && cmd_ready_out;
    // private maker ids fail id_sendable; payload capped to frame
    assign cmd_ok = id_sendable(cmd_id_in, maker_ids_en_in) && (cmd_len_in <= MAX_PAYLOAD);
    assign tx_valid_out = (state_ff == TX_ID) || (state_ff == TX_ERROR)
        || ((state_ff == TX_PAYLOAD) && fifo_valid);
    assign tx_fire = tx_valid_out && tx_ready_in;
    assign fifo_ready = (state_ff == TX_PAYLOAD) && tx_ready_in;
    // identifier first, payload behind it from the buffer
    assign tx_data_out = (state_ff == TX_PAYLOAD) ? fifo_data : id_ff;
    // a zero-length command is the identifier octet alone
    assign tx_last_out = (state_ff == TX_ERROR) || ((state_ff == TX_ID) && rem_ff == '0)
        || ((state_ff == TX_PAYLOAD) && rem_ff == 8'h01);
    // key octets checked as they leave
    assign key_bad_out = (state_ff == TX_PAYLOAD) && tx_fire && (id_ff == ID_KEYSTROKE)
        && !key_legal(fifo_data);

    // message state; a pending error report waits only for an idle link
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= TX_IDLE;
            id_ff <= BYTE_RST;
            rem_ff <= BYTE_RST;
        end else begin
            unique case (state_ff)
                TX_IDLE: begin
                    if (err_pend_ff) begin
                        state_ff <= TX_ERROR;
                        id_ff <= ID_UNRECOGNISED;
                    end else if (cmd_take && cmd_ok) begin
                        state_ff <= TX_ID;
                        id_ff <= cmd_id_in;
                        rem_ff <= cmd_len_in;
                    end
                end
                TX_ID: begin
                    if (tx_fire) begin
                        state_ff <= (rem_ff == '0) ? TX_IDLE : TX_PAYLOAD;
                    end
                end
                TX_PAYLOAD: begin
                    if (tx_fire) begin
                        rem_ff <= rem_ff - 8'h01;
                        if (rem_ff == 8'h01) begin
                            state_ff <= TX_IDLE;
                        end
                    end
                end
                TX_ERROR: begin
                    if (tx_fire) begin
                        state_ff <= TX_IDLE;
                    end
                end
            endcase
        end
    end

    // refusal pulse for an illegal identifier or oversize payload
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            cmd_reject_out <= 1'b0;
        end else begin
            cmd_reject_out <= cmd_take && !cmd_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive decoder

    logic [7:0] rx_idx_ff;
    logic [7:0] rx_id_ff;
    logic [7:0] rx_d2_ff;
    logic [7:0] cur_id;
    logic [7:0] cur_d2;
    logic rx_end;

    // the closing byte may itself be the identifier or the second octet
    assign cur_id = (rx_idx_ff == '0) ? rx_data_in : rx_id_ff;
    assign cur_d2 = (rx_idx_ff == 8'h01) ? rx_data_in : rx_d2_ff;
    // a bad frame is the framer's to reject, never decoded here
    assign rx_end = rx_valid_in && rx_last_in && rx_frame_ok_in;
    assign err_set = rx_end && !id_known(cur_id, maker_ids_en_in);

    // octet position and the first two octets of each message
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            rx_idx_ff <= BYTE_RST;
            rx_id_ff <= BYTE_RST;
            rx_d2_ff <= BYTE_RST;
        end else if (rx_valid_in) begin
            rx_idx_ff <= rx_last_in ? BYTE_RST : rx_idx_ff + 8'h01;
            if (rx_idx_ff == '0) begin
                rx_id_ff <= rx_data_in;
            end
            if (rx_idx_ff == 8'h01) begin
                rx_d2_ff <= rx_data_in;
            end
        end
    end

    // unknown answer queues error 241; a new one wins over the clear
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            err_pend_ff <= 1'b0;
        end else if (err_set) begin
            err_pend_ff <= 1'b1;
        end else if (state_ff == TX_ERROR && tx_fire) begin
            err_pend_ff <= 1'b0;
        end
    end

    // decoded answer pulse with identifier and first field
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            resp_valid_out <= 1'b0;
            resp_id_out <= BYTE_RST;
            resp_data_out <= BYTE_RST;
        end else begin
            resp_valid_out <= rx_end && !err_set;
            if (rx_end && !err_set) begin
                resp_id_out <= cur_id;
                resp_data_out <= cur_d2;
            end
        end
    end

    // alert and short-message state as last reported
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            alert_on_out <= 1'b0;
            short_msg_out <= 1'b0;
        end else if (rx_end) begin
            if (cur_id == ID_ALERT_ON || cur_id == ID_ALERT_OFF) begin
                alert_on_out <= (cur_id == ID_ALERT_ON);
            end
            // 101 carries a message, 102 says none
            if (cur_id == ID_SHORT_MSG || cur_id == ID_NO_SHORT_MSG) begin
                short_msg_out <= (cur_id == ID_SHORT_MSG);
            end
        end
    end

    // last error identifier reported by the handset
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            dev_error_out <= BYTE_RST;
        end else if (rx_end && cur_id >= ERROR_LO && id_known(cur_id, maker_ids_en_in)) begin
            dev_error_out <= cur_id;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    tx_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
        else $error("tx byte dropped before taken");
    id_legal_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        state_ff == TX_ID |-> id_sendable(id_ff, maker_ids_en_in))
        else $error("illegal identifier on link");
    priv_never_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        tx_valid_out && state_ff == TX_ID |-> !(id_ff >= MAKER_PRIV_LO && id_ff <= MAKER_PRIV_HI))
        else $error("private maker id sent");
    flow_clash_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        state_ff == TX_ID |-> id_ff != FLOW_NAK && id_ff != FLOW_ACK
            && id_ff != FLOW_RESUME && id_ff != FLOW_STOP)
        else $error("identifier equals flow code");
    reject_pulse_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        cmd_take && !cmd_ok |=> cmd_reject_out && state_ff == TX_IDLE)
        else $error("bad command not refused");
    err_queue_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        err_set && cmd_ready_out && !cmd_valid_in
            |=> err_pend_ff ##1 (state_ff == TX_ERROR && tx_data_out == ID_UNRECOGNISED))
        else $error("error 241 not queued");
    alert_track_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        rx_end && cur_id == ID_ALERT_OFF |=> !alert_on_out)
        else $error("alert state not cleared");
    single_octet_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        tx_fire && state_ff == TX_ID && rem_ff == '0 |-> tx_last_out ##1 state_ff != TX_PAYLOAD)
        else $error("single octet command ran on");
    key_flag_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
        key_bad_out |-> id_ff == ID_KEYSTROKE && !key_legal(tx_data_out))
        else $error("key warning without bad key");
    cmd_cov_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n)
        tx_fire && state_ff == TX_PAYLOAD && tx_last_out && id_ff == ID_KEYSTROKE);
    alert_cov_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n)
        rx_end && cur_id == ID_ALERT_ON);
    err_cov_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n)
        state_ff == TX_ERROR && tx_fire);
    stall_cov_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n)
        pay_valid_in && !pay_ready_out);
endmodule : tpmi_host

// file: verification/tpmi_handset_model.sv
// handset model: decodes host messages, answers requests, keeps its state
`timescale 1ns/1ps
module tpmi_handset_model
    import tpmi_pkg::*;
(
    // clock and bench controls
    input wire logic clk_sys_in,
    input wire logic slow_in,
    input wire logic alert_in,
    // bytes from the host
    input wire logic tx_valid_in,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_last_in,
    output logic tx_ready_out,
    // bytes to the host
    output logic rx_valid_out,
    output logic [7:0] rx_data_out,
    output logic rx_last_out,
    output logic rx_frame_ok_out
);
    logic [7:0] got[$];
    logic [9:0] ans[$];
    logic [7:0] head = 8'h00;
    logic [7:0] vol = 8'h04;
    logic [7:0] bearer = 8'h00;
    logic in_msg = 1'b0;
    logic hook_up = 1'b0;
    ////////////////////////////////////////
    // bench-ordered messages, good or broken frame
    task automatic inject(input logic [7:0] id, input logic ok);
        ans.push_back({ok, 1'b1, id});
    endtask : inject
    // answer of one or two octets
    task automatic reply(input logic [7:0] id, input logic [7:0] dat, input logic two);
        ans.push_back({1'b1, !two, id});
        if (two) ans.push_back({2'b11, dat});
    endtask : reply
    // capture bytes and act once a message ends
    always @(posedge clk_sys_in) begin
        if (tx_valid_in && tx_ready_out) begin
            got.push_back(tx_data_in);
            if (!in_msg) head = tx_data_in;
            in_msg = !tx_last_in;
            if (tx_last_in) begin
                case (head)
                    ID_STATUS_REQ: reply(ID_STATUS_RESP, 8'h0a, 1'b1);
                    ID_INDICATION_REQ: reply(ID_INDICATION_RESP, 8'h01, 1'b1);
                    ID_POWER_REQ: reply(ID_POWER_RESP, 8'h05, 1'b1);
                    // current alert state, only on request
                    ID_ALERT_REQ: reply(alert_in ? ID_ALERT_ON : ID_ALERT_OFF, 8'h00, 1'b0);
                    ID_SHORT_MSG_REQ: reply(ID_NO_SHORT_MSG, 8'h00, 1'b0);
                    ID_VOLUME_UP: vol = vol + 8'h01;
                    ID_VOLUME_DOWN: vol = vol - 8'h01;
                    ID_HANDSET_DOWN: hook_up = 1'b0;
                    ID_HANDSET_UP: hook_up = 1'b1;
                    ID_BEARER_SELECT: bearer = tx_data_in;
                    ID_FULL_RESET: vol = 8'h04;
                    ID_KEYSTROKE, ID_UNRECOGNISED: ;
                    default: reply(ID_UNRECOGNISED, 8'h00, 1'b0);
                endcase
            end
        end
    end
    // drive after the edge; idle data toggles so a stale byte never looks held
    initial begin
        {rx_valid_out, rx_last_out, rx_frame_ok_out, rx_data_out} = '0;
        tx_ready_out = 1'b1;
        forever begin
            @(posedge clk_sys_in);
            #1;
            tx_ready_out = slow_in ? !tx_ready_out : 1'b1;
            rx_valid_out = (ans.size() > 0);
            if (rx_valid_out) {rx_frame_ok_out, rx_last_out, rx_data_out} = ans.pop_front();
            else rx_data_out = ~rx_data_out;
        end
    end
endmodule : tpmi_handset_model

// file: verification/tpmi_host_tb_top.sv
// self-checking bench for the simulator-side message interpreter
`timescale 1ns/1ps
module tpmi_host_tb_top
    import tpmi_pkg::*;
;
    logic clk_sys_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic maker_ids_en_in = 1'b0, cmd_valid_in = 1'b0, pay_valid_in = 1'b0;
    logic slow = 1'b0, alert = 1'b0;
    logic [7:0] cmd_id_in = 8'h00, cmd_len_in = 8'h00, pay_data_in = 8'h00;
    logic cmd_ready_out, cmd_reject_out, pay_ready_out, tx_valid_out, tx_ready_in, tx_last_out;
    logic key_bad_out, rx_valid_in, rx_last_in, rx_frame_ok_in, resp_valid_out;
    logic alert_on_out, short_msg_out;
    logic [7:0] tx_data_out, rx_data_in, resp_id_out, resp_data_out, dev_error_out, last_id;
    int fail_count = 0, n_tests = 0, rej = 0, bad = 0, rc = 0, s, r;
    tpmi_host u_dut (.clk_sys_in, .arst_n_in, .maker_ids_en_in, .cmd_valid_in, .cmd_ready_out,
        .cmd_id_in, .cmd_len_in, .cmd_reject_out, .pay_valid_in, .pay_ready_out, .pay_data_in,
        .tx_valid_out, .tx_ready_in, .tx_data_out, .tx_last_out, .key_bad_out, .rx_valid_in,
        .rx_data_in, .rx_last_in, .rx_frame_ok_in, .resp_valid_out, .resp_id_out,
        .resp_data_out, .alert_on_out, .short_msg_out, .dev_error_out);
    tpmi_handset_model u_dev (.clk_sys_in(clk_sys_in), .slow_in(slow), .alert_in(alert),
        .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out), .tx_last_in(tx_last_out),
        .tx_ready_out(tx_ready_in), .rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in),
        .rx_last_out(rx_last_in), .rx_frame_ok_out(rx_frame_ok_in));
    ////////////////////////////////////////
    // clock and event counters
    initial forever #10 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        rej += int'(cmd_reject_out === 1'b1);
        bad += int'(key_bad_out === 1'b1 && tx_valid_out === 1'b1 && tx_ready_in === 1'b1);
        if (resp_valid_out === 1'b1) begin
            rc++;
            last_id = resp_id_out;
        end
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : tick
    // request held until the edge that sees ready
    task automatic send_cmd(input logic [7:0] id, input logic [7:0] len);
        int n = 0;
        tick(1);
        {cmd_valid_in, cmd_id_in, cmd_len_in} = {1'b1, id, len};
        while (cmd_ready_out !== 1'b1 && n < 500) begin
            tick(1);
            n++;
        end
        check("cmd ready", cmd_ready_out, 8'h01);
        tick(1);
        cmd_valid_in = 1'b0;
    endtask : send_cmd
    task automatic push(input logic [7:0] d);
        int n = 0;
        {pay_valid_in, pay_data_in} = {1'b1, d};
        while (pay_ready_out !== 1'b1 && n < 50) begin
            tick(1);
            n++;
        end
        check("pay ready", pay_ready_out, 8'h01);
        tick(1);
    endtask : push
    task automatic wait_got(input int sz);
        for (int n = 0; n < 2000 && u_dev.got.size() < sz; n++) tick(1);
        check("bytes sent", 8'(u_dev.got.size()), 8'(sz));
    endtask : wait_got
    task automatic wait_resp(input int c);
        for (int n = 0; n < 2000 && rc < c; n++) tick(1);
    endtask : wait_resp
    ////////////////////////////////////////
    task automatic t_requests();
        logic [7:0] q[6] = '{ID_STATUS_REQ, ID_INDICATION_REQ, ID_POWER_REQ, ID_ALERT_REQ,
            ID_ALERT_REQ, ID_SHORT_MSG_REQ};
        logic [7:0] a[6] = '{ID_STATUS_RESP, ID_INDICATION_RESP, ID_POWER_RESP, ID_ALERT_ON,
            ID_ALERT_OFF, ID_NO_SHORT_MSG};
        for (int i = 0; i < 6; i++) begin
            alert = (i == 3);
            r = rc;
            send_cmd(q[i], 8'h00);
            wait_resp(r + 1);
            check("response id", last_id, a[i]);
            if (i == 0) check("status data", resp_data_out, 8'h0a);
            if (i == 3) check("alert flag", alert_on_out, 8'h01);
        end
        check("alert flag", alert_on_out, 8'h00);
        check("short msg flag", short_msg_out, 8'h00);
    endtask : t_requests
    task automatic t_cmds();
        logic [7:0] c[5] = '{ID_VOLUME_UP, ID_VOLUME_DOWN, ID_HANDSET_DOWN, ID_HANDSET_UP,
            ID_FULL_RESET};
        for (int i = 0; i < 5; i++) begin
            s = u_dev.got.size();
            send_cmd(c[i], 8'h00);
            wait_got(s + 1);
            check("command", u_dev.got[s], c[i]);
        end
        push(8'h02);
        pay_valid_in = 1'b0;
        send_cmd(ID_BEARER_SELECT, 8'h01);
        wait_got(s + 3);
        check("bearer", u_dev.bearer, 8'h02);
    endtask : t_cmds
    // fill the fifo to refusal, then drain it against a stalling handset
    task automatic t_keystroke_sequence_cmd();
        logic [7:0] k[8] = '{KEY_HASH, KEY_STAR, KEY_PLUS, KEY_DIGIT0, KEY_DIGIT9, KEY_END,
            KEY_SEND, 8'h41};
        s = u_dev.got.size();
        r = bad;
        for (int i = 0; i < 8; i++) push(k[i]);
        pay_valid_in = 1'b0;
        check("fifo full", pay_ready_out, 8'h00);
        slow = 1'b1;
        send_cmd(ID_KEYSTROKE, 8'h08);
        wait_got(s + 9);
        slow = 1'b0;
        check("key id", u_dev.got[s], ID_KEYSTROKE);
        for (int i = 0; i < 8; i++) check("key", u_dev.got[s + 1 + i], k[i]);
        check("bad keystroke_sequence_cmd", 8'(bad - r), 8'h01);
        check("fifo empty", pay_ready_out, 8'h01);
    endtask : t_keystroke_sequence_cmd
    task automatic t_refuse();
        logic [7:0] b[9] = '{8'h00, FLOW_ACK, FLOW_STOP, GENERAL_LO, 8'h3b, MAKER_LO,
            MAKER_PRIV_LO, 8'hf3, ID_STATUS_REQ};
        for (int i = 0; i < 9; i++) begin
            s = u_dev.got.size();
            r = rej;
            send_cmd(b[i], (i == 8) ? 8'hff : 8'h00);
            tick(3);
            check("refused", 8'(rej - r), 8'h01);
            check("none sent", 8'(u_dev.got.size() - s), 8'h00);
        end
    endtask : t_refuse
    task automatic t_errors();
        maker_ids_en_in = 1'b1;
        s = u_dev.got.size();
        r = rc;
        send_cmd(MAKER_LO, 8'h00);
        wait_got(s + 1);
        maker_ids_en_in = 1'b0;
        check("maker id", u_dev.got[s], MAKER_LO);
        wait_resp(r + 1);
        check("device error", dev_error_out, ID_UNRECOGNISED);
        u_dev.inject(8'h99, 1'b1);
        wait_got(s + 2);
        check("error sent", u_dev.got[s + 1], ID_UNRECOGNISED);
        r = rc;
        u_dev.inject(8'h98, 1'b0);
        tick(12);
        check("bad frame", 8'(u_dev.got.size() - s), 8'h02);
        u_dev.inject(ID_UNPERFORMABLE, 1'b1);
        wait_resp(r + 1);
        check("device error", dev_error_out, ID_UNPERFORMABLE);
        u_dev.inject(ID_INTERNAL_FAULT, 1'b1);
        wait_resp(r + 2);
        check("device error", dev_error_out, ID_INTERNAL_FAULT);
        u_dev.inject(ID_SHORT_MSG, 1'b1);
        wait_resp(r + 3);
        check("short msg flag", short_msg_out, 8'h01);
    endtask : t_errors
    ////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk_sys_in);
        #1;
        arst_n_in = 1'b1;
        tick(3);
        check("idle ready", cmd_ready_out, 8'h01);
        check("idle tx", tx_valid_out, 8'h00);
        t_requests();
        t_cmds();
        t_keystroke_sequence_cmd();
        t_refuse();
        t_errors();
        close_out();
    end
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #400us;
        fail_count++;
        close_out();
    end
endmodule : tpmi_host_tb_top
